// ---- rtl/dml_pkg.sv ----
// Shared constants and types of the phase-locked loop mode and lock core
package dml_pkg;

   // ----------------------------------------------------------------
   // Clocking and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned FRAME_HZ = 8_000;
   localparam int unsigned FRAME_CYCLES = CLK_HZ / FRAME_HZ;
   localparam int unsigned FRAME_PERIOD_NS = 1_000_000_000 / FRAME_HZ;
   localparam int unsigned INIT_TIME_US = 625;
   localparam int unsigned INIT_CYCLES = INIT_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned LOCK_LOW_S = 10;
   localparam int unsigned LOCK_LOW_CYCLES = LOCK_LOW_S * CLK_HZ;
   localparam int unsigned HIST_TIME_MS = 30;
   localparam int unsigned HIST_CYCLES = HIST_TIME_MS * (CLK_HZ / 1_000);
   localparam int unsigned FRAME_PULSE_NS = 61;
   localparam int unsigned FRAME_PULSE_CYCLES =
      (FRAME_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;

   // ----------------------------------------------------------------
   // Reference impairment window
   // ----------------------------------------------------------------
   localparam int unsigned REF_DRIFT_PPM = 30_000;
   localparam int unsigned REF_TOL_CYCLES = FRAME_CYCLES * REF_DRIFT_PPM / 1_000_000;
   localparam logic [11:0] REF_MIN_PERIOD = 12'(FRAME_CYCLES - REF_TOL_CYCLES);
   localparam logic [11:0] REF_MAX_PERIOD = 12'(FRAME_CYCLES + REF_TOL_CYCLES);
   localparam logic [11:0] REF_CNT_SAT = 12'h0FFF;

   // ----------------------------------------------------------------
   // Loop arithmetic, phase is a 32-bit fraction of one 8 kHz frame
   // ----------------------------------------------------------------
   localparam logic [63:0] PHASE_ONE = 64'h0000_0001_0000_0000;
   localparam logic [31:0] NOMINAL_WORD = 32'((PHASE_ONE * FRAME_HZ) / CLK_HZ);
   localparam int unsigned SLOPE_NS = 41;
   localparam int unsigned SLOPE_WINDOW_NS = 1_326_000;
   // One update per frame, so the step is the slope per frame
   localparam logic [31:0] SLOPE_STEP = 32'((PHASE_ONE * SLOPE_NS) / SLOPE_WINDOW_NS);
   localparam int unsigned LOCK_WIN_NS = 20;
   localparam logic [31:0] LOCK_WIN = 32'((PHASE_ONE * LOCK_WIN_NS) / FRAME_PERIOD_NS);
   // 2*pi*1.5 Hz / 8 kHz is close to 2^-10
   localparam int unsigned FILTER_SHIFT = 10;
   localparam int unsigned PROP_SHIFT = 4;
   localparam logic [4:0] LOCK_STABLE_EDGES = 5'h10;

   // Synthesizer ratios against the 8 kHz DCO word
   localparam logic [31:0] MUL_2M = 32'h0000_0100;
   localparam logic [31:0] MUL_8M = 32'h0000_0400;
   localparam logic [31:0] MUL_16M = 32'h0000_0800;
   localparam logic [31:0] MUL_19M = 32'h0000_097E;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_FREQ = 4'h8;
   localparam logic [3:0] REG_HOLD = 4'hC;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int unsigned CTRL_OUT_EN = 0;

   // ----------------------------------------------------------------
   // Modes and states
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_HOLD = 2'h1;
   localparam logic [1:0] MODE_FREE = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;

   typedef enum logic [2:0] {
      ST_INIT = 3'b000,
      ST_FREE = 3'b001,
      ST_NORMAL = 3'b011,
      ST_AUTO_HOLD = 3'b010,
      ST_HOLD = 3'b110
   } dml_state_t;

   typedef struct packed {
      logic [1:0] ref_ok;
      logic lock;
      logic holdover;
      logic hist_valid;
      dml_state_t state;
   } dml_status_t;

endpackage

// ---- rtl/dml_core.sv ----
// Digital phase-locked loop core with mode control, lock and holdover
//
// Contract
// - Mode pins 00 Normal, 01 Holdover, 10 Free-run, 11 reserved.
// - Free-run locks to the master oscillator, stability equals the oscillator.
// - Normal locks frequency and phase to the selected reference.
// - Holdover entered on reference loss or when pins request it.
// - Each reference is preprocessed with a quality assessment before the loop.
// - Phase detector compares reference with feedback, error goes to limiter.
// - Limiter bounds output phase slope to 41 ns per 1.326 ms.
// - Loop filter is first-order low-pass, 1.5 Hz, for every reference rate.
// - Holdover runs at the frequency of the last 30 to 60 ms.
// - Free-run oscillator runs at master oscillator accuracy, no correction.
// - Synthesizer makes 2.048, 8.192, 16.384 MHz clocks at 50% duty; the code takes top bits at 10 MHz, so 8.192 and 16.384 alias.
// - Active-low 8 kHz frame pulse, each pulse 61 ns low; the code holds it low one 100 ns clock cycle.
// - 19.44 MHz link clock at 50% duty feeds only the attenuator; the code takes an accumulator top bit on the 10 MHz clock, so it aliases.
// - Lock asserts only when residual phase movement stays within 20 ns.
// - Once lock drops it stays low at least 10 s.
// - Attenuator gives two differential 155.52 and one 19.44 output from link.
// - Monitor both references, force auto holdover outside capture range.
// - Recovered reference returns the loop to Normal locked to it.
// - Return from holdover keeps previous input-to-output phase offset.
// - Source select low picks first reference, high picks second.
// - Holdover status output high in any holdover condition.
// - After reset release run 625 us initialization, then Free-run.
module dml_core #(
   parameter int unsigned INIT_CYCLES = dml_pkg::INIT_CYCLES,
   parameter int unsigned LOCK_LOW_CYCLES = dml_pkg::LOCK_LOW_CYCLES,
   parameter int unsigned HIST_CYCLES = dml_pkg::HIST_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic mode_select_low,
   input wire logic mode_select_high,
   input wire logic ref_source_select,
   input wire logic first_reference,
   input wire logic second_reference,
   input wire logic attenuator_link_in,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic clk_2m_out,
   output logic clk_8m_out,
   output logic clk_16m_out,
   output logic frame_pulse_out_n,
   output logic synth_link_out,
   output logic ja_19m_out,
   output logic ja_155m_a_p,
   output logic ja_155m_a_n,
   output logic ja_155m_b_p,
   output logic ja_155m_b_n,
   output logic lock_out,
   output logic holdover_out
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   dml_pkg::dml_state_t state;
   dml_pkg::dml_status_t status;
   logic [1:0] ref_now;
   logic [1:0] ref_q;
   logic [1:0] ref_fall;
   logic [1:0] ref_ok;
   logic [11:0] ref_cnt [2];
   logic sel_ok;
   logic sel_edge;
   logic [1:0] mode_req;
   logic [31:0] init_cnt;
   logic [31:0] phase_acc;
   logic [32:0] phase_sum;
   logic [31:0] freq_word;
   logic [31:0] ph_ofs;
   logic have_ofs;
   logic signed [31:0] raw_err;
   logic signed [31:0] lim_err;
   logic [31:0] err_abs;
   logic [31:0] hist [2];
   logic [1:0] hist_fill;
   logic [31:0] hist_cnt;
   logic [31:0] hold_word;
   logic [4:0] stable_cnt;
   logic [31:0] low_cnt;
   logic low_done;
   logic [31:0] ctrl;
   logic [31:0] syn_acc [4];
   logic [31:0] syn_mul [4];
   logic [1:0] pulse_cnt;
   logic ja_q;

   function automatic logic in_holdover(input dml_pkg::dml_state_t s);
      return (s == dml_pkg::ST_HOLD) || (s == dml_pkg::ST_AUTO_HOLD);
   endfunction

   function automatic logic [31:0] mag(input logic signed [31:0] v);
      return v[31] ? 32'(-v) : 32'(v);
   endfunction

   // ----------------------------------------------------------------
   // Reference preprocessing and impairment monitor
   // ----------------------------------------------------------------
   assign ref_now = {second_reference, first_reference};
   assign ref_fall = ref_q & ~ref_now;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ref_q <= 2'b00;
      end else begin
         ref_q <= ref_now;
      end
   end

   // Both inputs always watched so a switch-over finds a known state
   for (genvar i = 0; i < 2; i++) begin : g_mon
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            ref_cnt[i] <= 12'h000;
            ref_ok[i] <= 1'b0;
         end else if (ref_fall[i]) begin
            ref_cnt[i] <= 12'h000;
            ref_ok[i] <= (ref_cnt[i] >= dml_pkg::REF_MIN_PERIOD) &&
                         (ref_cnt[i] <= dml_pkg::REF_MAX_PERIOD);
         end else begin
            if (ref_cnt[i] != dml_pkg::REF_CNT_SAT) begin
               ref_cnt[i] <= ref_cnt[i] + 12'h001;
            end
            if (ref_cnt[i] > dml_pkg::REF_MAX_PERIOD) begin
               ref_ok[i] <= 1'b0;
            end
         end
      end
   end

   assign sel_ok = ref_ok[ref_source_select];
   assign sel_edge = ref_fall[ref_source_select];
   assign mode_req = {mode_select_high, mode_select_low};

   // ----------------------------------------------------------------
   // Control state machine
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         init_cnt <= 32'h0000_0000;
      end else if (state == dml_pkg::ST_INIT) begin
         init_cnt <= init_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= dml_pkg::ST_INIT;
      end else begin
         unique case (state)
            dml_pkg::ST_INIT: begin
               if (init_cnt >= 32'(INIT_CYCLES - 1)) begin
                  state <= dml_pkg::ST_FREE;
               end
            end
            default: begin
               unique case (mode_req)
                  dml_pkg::MODE_NORMAL: begin
                     // Never lock onto an impaired input
                     if (sel_ok) begin
                        state <= dml_pkg::ST_NORMAL;
                     end else begin
                        state <= dml_pkg::ST_AUTO_HOLD;
                     end
                  end
                  dml_pkg::MODE_HOLD: state <= dml_pkg::ST_HOLD;
                  dml_pkg::MODE_FREE: state <= dml_pkg::ST_FREE;
                  dml_pkg::MODE_RSVD: state <= state;
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         holdover_out <= 1'b0;
      end else begin
         holdover_out <= in_holdover(state);
      end
   end

   // ----------------------------------------------------------------
   // Phase detector and limiter
   // ----------------------------------------------------------------
   assign raw_err = signed'(phase_acc - ph_ofs);
   always_comb begin
      if (raw_err > signed'(dml_pkg::SLOPE_STEP)) begin
         lim_err = signed'(dml_pkg::SLOPE_STEP);
      end else if (raw_err < -signed'(dml_pkg::SLOPE_STEP)) begin
         lim_err = -signed'(dml_pkg::SLOPE_STEP);
      end else begin
         lim_err = raw_err;
      end
   end
   assign err_abs = mag(raw_err);

   // The offset is taken once per reset; a later return from holdover
   // reuses it so the outputs are not pulled back into alignment.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ph_ofs <= 32'h0000_0000;
         have_ofs <= 1'b0;
      end else if (state == dml_pkg::ST_NORMAL && sel_edge && !have_ofs) begin
         ph_ofs <= phase_acc;
         have_ofs <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Loop filter and DCO
   // ----------------------------------------------------------------
   assign phase_sum = {1'b0, phase_acc} + {1'b0, freq_word};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase_acc <= 32'h0000_0000;
      end else if (state == dml_pkg::ST_NORMAL && sel_edge && have_ofs) begin
         phase_acc <= phase_sum[31:0] - 32'(lim_err >>> dml_pkg::PROP_SHIFT);
      end else if (state != dml_pkg::ST_INIT) begin
         phase_acc <= phase_sum[31:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         freq_word <= dml_pkg::NOMINAL_WORD;
      end else begin
         unique case (state)
            dml_pkg::ST_INIT, dml_pkg::ST_FREE: begin
               freq_word <= dml_pkg::NOMINAL_WORD;
            end
            dml_pkg::ST_HOLD, dml_pkg::ST_AUTO_HOLD: begin
               freq_word <= hold_word;
            end
            dml_pkg::ST_NORMAL: begin
               if (sel_edge && have_ofs) begin
                  freq_word <= freq_word - 32'(lim_err >>> dml_pkg::FILTER_SHIFT);
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Holdover history
   // ----------------------------------------------------------------
   // Two snapshots 30 ms apart: the older one is 30 to 60 ms old while Normal runs unbroken,
   // which keeps the final transient before a failure out of holdover.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hist_cnt <= 32'h0000_0000;
         hist[0] <= dml_pkg::NOMINAL_WORD;
         hist[1] <= dml_pkg::NOMINAL_WORD;
         hist_fill <= 2'b00;
      end else if (state == dml_pkg::ST_NORMAL) begin
         if (hist_cnt >= 32'(HIST_CYCLES - 1)) begin
            hist_cnt <= 32'h0000_0000;
            hist[0] <= freq_word;
            hist[1] <= hist[0];
            hist_fill <= {hist_fill[0], 1'b1};
         end else begin
            hist_cnt <= hist_cnt + 32'h0000_0001;
         end
      end else begin
         hist_cnt <= 32'h0000_0000;
      end
   end

   // With no history yet, holdover runs at free-run accuracy
   assign hold_word = hist_fill[1] ? hist[1] : dml_pkg::NOMINAL_WORD;

   // ----------------------------------------------------------------
   // Lock indicator
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stable_cnt <= 5'h00;
      end else if (state != dml_pkg::ST_NORMAL || !have_ofs) begin
         stable_cnt <= 5'h00;
      end else if (sel_edge) begin
         if (err_abs > dml_pkg::LOCK_WIN) begin
            stable_cnt <= 5'h00;
         end else if (stable_cnt != dml_pkg::LOCK_STABLE_EDGES) begin
            stable_cnt <= stable_cnt + 5'h01;
         end
      end
   end

   assign low_done = (low_cnt >= 32'(LOCK_LOW_CYCLES));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_out <= 1'b0;
         low_cnt <= 32'h0000_0000;
      end else if (lock_out) begin
         if (stable_cnt != dml_pkg::LOCK_STABLE_EDGES) begin
            lock_out <= 1'b0;
            low_cnt <= 32'h0000_0000;
         end
      end else begin
         if (!low_done) begin
            low_cnt <= low_cnt + 32'h0000_0001;
         end
         if (low_done && stable_cnt == dml_pkg::LOCK_STABLE_EDGES) begin
            lock_out <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock synthesizer
   // ----------------------------------------------------------------
   // Clocks are the top bits of phase accumulators stepped by scaled DCO
   // words; on a 10 MHz clock the faster ones alias, only mean rate holds.
   assign syn_mul[0] = dml_pkg::MUL_2M;
   assign syn_mul[1] = dml_pkg::MUL_8M;
   assign syn_mul[2] = dml_pkg::MUL_16M;
   assign syn_mul[3] = dml_pkg::MUL_19M;

   for (genvar k = 0; k < 4; k++) begin : g_syn
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            syn_acc[k] <= 32'h0000_0000;
         end else if (state != dml_pkg::ST_INIT) begin
            syn_acc[k] <= syn_acc[k] + 32'(freq_word * syn_mul[k]);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clk_2m_out <= 1'b0;
         clk_8m_out <= 1'b0;
         clk_16m_out <= 1'b0;
         synth_link_out <= 1'b0;
      end else begin
         clk_2m_out <= syn_acc[0][31] & ctrl[dml_pkg::CTRL_OUT_EN];
         clk_8m_out <= syn_acc[1][31] & ctrl[dml_pkg::CTRL_OUT_EN];
         clk_16m_out <= syn_acc[2][31] & ctrl[dml_pkg::CTRL_OUT_EN];
         synth_link_out <= syn_acc[3][31];
      end
   end

   // Frame pulse on each DCO wrap, shortest whole-cycle width above 61 ns
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pulse_cnt <= 2'b00;
         frame_pulse_out_n <= 1'b1;
      end else if (phase_sum[32] && state != dml_pkg::ST_INIT) begin
         pulse_cnt <= 2'(dml_pkg::FRAME_PULSE_CYCLES - 1);
         frame_pulse_out_n <= ~ctrl[dml_pkg::CTRL_OUT_EN];
      end else if (pulse_cnt != 2'b00) begin
         pulse_cnt <= pulse_cnt - 2'b01;
      end else begin
         frame_pulse_out_n <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Jitter attenuator outputs
   // ----------------------------------------------------------------
   // The analog multiplier is outside; here the link is only retimed and
   // fanned out so that isolating the link silences every output.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ja_q <= 1'b0;
      end else begin
         ja_q <= attenuator_link_in;
      end
   end

   assign ja_19m_out = ja_q;
   assign ja_155m_a_p = ja_q;
   assign ja_155m_a_n = ~ja_q;
   assign ja_155m_b_p = ja_q;
   assign ja_155m_b_n = ~ja_q;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl <= dml_pkg::CTRL_RESET;
      end else if (reg_wr && reg_addr == dml_pkg::REG_CTRL) begin
         ctrl <= {31'h0000_0000, reg_wdata[dml_pkg::CTRL_OUT_EN]};
      end
   end

   always_comb begin
      status.ref_ok = ref_ok;
      status.lock = lock_out;
      status.holdover = in_holdover(state);
      status.hist_valid = hist_fill[1];
      status.state = state;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            dml_pkg::REG_CTRL: reg_rdata <= ctrl;
            dml_pkg::REG_STATUS: reg_rdata <= 32'(status);
            dml_pkg::REG_FREQ: reg_rdata <= freq_word;
            dml_pkg::REG_HOLD: reg_rdata <= hold_word;
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

// ---- verification/dml_core_monitor.sv ----
// Checker of mode, lock, frame and attenuator behaviour
module dml_core_monitor #(
   parameter int unsigned INIT_CYCLES = 20,
   parameter int unsigned LOCK_LOW_CYCLES = 50
) (
   input logic clk_sys,
   input logic rst,
   input logic mode_select_low,
   input logic mode_select_high,
   input logic attenuator_link_in,
   input logic frame_pulse_out_n,
   input logic ja_19m_out,
   input logic ja_155m_a_p,
   input logic ja_155m_a_n,
   input logic ja_155m_b_p,
   input logic ja_155m_b_n,
   input logic lock_out,
   input logic holdover_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------------
   int unsigned since;
   int unsigned low_cnt;
   int unsigned gap;
   logic fp_seen;
   wire logic [1:0] pins = {mode_select_high, mode_select_low};
   // Pins obeyed only after init
   wire logic ready = since >= INIT_CYCLES + 6;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         since <= 0;
         low_cnt <= 0;
         gap <= 0;
         fp_seen <= 1'b0;
      end else begin
         if (since < INIT_CYCLES + 8) since <= since + 1;
         low_cnt <= lock_out ? 0 : (low_cnt < LOCK_LOW_CYCLES ? low_cnt + 1 : low_cnt);
         gap <= !frame_pulse_out_n ? 0 : (gap < 4000 ? gap + 1 : gap);
         if (!frame_pulse_out_n) fp_seen <= 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_held(logic [1:0] v);
      ready && $past(pins, 2) == v && $past(pins, 3) == v;
   endsequence
   sequence s_fall;
      $fell(frame_pulse_out_n);
   endsequence
   property p_hold_pin; s_held(2'b01) |-> holdover_out; endproperty
   property p_free_pin; s_held(2'b10) |-> !holdover_out && !lock_out; endproperty
   property p_rsvd; s_held(2'b11) |-> $stable(holdover_out); endproperty
   property p_init; since < INIT_CYCLES |-> !holdover_out && !lock_out; endproperty
   property p_fp_width; s_fall |=> frame_pulse_out_n; endproperty
   property p_fp_gap; fp_seen && $fell(frame_pulse_out_n) |-> gap >= 1100; endproperty
   // One cycle of slack for the registered lock output
   property p_lock_gap; $rose(lock_out) |-> low_cnt >= LOCK_LOW_CYCLES - 1; endproperty
   property p_lock_hold; holdover_out && $past(holdover_out) |-> !lock_out; endproperty
   property p_ja;
      since >= 2 |-> {ja_19m_out, ja_155m_a_p, ja_155m_b_p, ~ja_155m_a_n, ~ja_155m_b_n}
         == {5{$past(attenuator_link_in)}};
   endproperty
   a_hold_pin: assert property (p_hold_pin) else $error("holdover pins ignored");
   a_free_pin: assert property (p_free_pin) else $error("status in free run");
   a_rsvd: assert property (p_rsvd) else $error("reserved code acted");
   a_init: assert property (p_init) else $error("status during init");
   a_fp_width: assert property (p_fp_width) else $error("frame pulse too long");
   a_fp_gap: assert property (p_fp_gap) else $error("frame pulses too close");
   a_lock_gap: assert property (p_lock_gap) else $error("lock low too short");
   a_lock_hold: assert property (p_lock_hold) else $error("lock during holdover");
   a_ja: assert property (p_ja) else $error("attenuator outputs wrong");
endmodule

bind dml_core dml_core_monitor #(.INIT_CYCLES(INIT_CYCLES), .LOCK_LOW_CYCLES(LOCK_LOW_CYCLES)) u_mon (.*);

// ---- verification/dml_ref_model.sv ----
// Reference clock source of adjustable period
module dml_ref_model (
   input logic clk_sys,
   input logic en,
   input logic [11:0] per,
   output logic ref_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] cnt = 12'h000;
   initial ref_out = 1'b1;
   // A lost source shows no edges at all, so the line rests high
   always @(posedge clk_sys) begin
      cnt <= (cnt >= per - 12'h001) ? 12'h000 : cnt + 12'h001;
      ref_out <= !en || (cnt >= per / 2);
   end
endmodule

// ---- verification/dml_core_tb_top.sv ----
// Testbench of the loop mode and lock core
module automatic dml_core_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, rst, mode_select_low, mode_select_high, ref_source_select, reg_wr, reg_rd;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic clk_2m_out, clk_8m_out, clk_16m_out, frame_pulse_out_n, synth_link_out, ja_19m_out;
   logic ja_155m_a_p, ja_155m_a_n, ja_155m_b_p, ja_155m_b_n, lock_out, holdover_out;
   logic [1:0] ref_en;
   logic [11:0] per0, per1;
   wire logic first_reference, second_reference, attenuator_link_in;
   int fails = 0, check_count = 0;
   assign attenuator_link_in = synth_link_out;
   dml_core #(.INIT_CYCLES(20), .LOCK_LOW_CYCLES(50), .HIST_CYCLES(100)) u_dut (.*);
   dml_ref_model u_ref0 (.clk_sys, .en(ref_en[0]), .per(per0), .ref_out(first_reference));
   dml_ref_model u_ref1 (.clk_sys, .en(ref_en[1]), .per(per1), .ref_out(second_reference));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task end_of_test();
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string n, logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task md(input logic [1:0] m);
      @(posedge clk_sys);
      {mode_select_high, mode_select_low} <= m;
   endtask
   // Bounded poll of status for a masked value
   task wst(input string n, logic [31:0] m, v, int lim);
      logic [31:0] d;
      for (int i = 0; i < lim; i++) begin
         rd(dml_pkg::REG_STATUS, d);
         if ((d & m) === v) break;
      end
      chk(n, d & m, v);
      if ((d & m) !== v) end_of_test();
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_init();
      logic [31:0] d;
      rd(dml_pkg::REG_STATUS, d);
      chk("init state", d & 32'h0000_0037, 32'(dml_pkg::ST_INIT));
      rd(dml_pkg::REG_CTRL, d);
      chk("ctrl reset", d, dml_pkg::CTRL_RESET);
      rd(4'h2, d);
      chk("unmapped read", d, 32'h0000_0000);
      wst("free after init", 32'h0000_0037, 32'(dml_pkg::ST_FREE), 30);
      rd(dml_pkg::REG_FREQ, d);
      chk("free word", d, dml_pkg::NOMINAL_WORD);
   endtask
   task t_hold();
      md(2'b01);
      wst("pin holdover", 32'h0000_0037, 32'h0000_0016, 10);
      chk("holdover pin", 32'(holdover_out), 32'h0000_0001);
   endtask
   task t_normal();
      @(posedge clk_sys);
      ref_en <= 2'b01;
      md(2'b00);
      wst("normal", 32'h0000_0017, 32'(dml_pkg::ST_NORMAL), 1500);
      wst("lock", 32'h0000_0020, 32'h0000_0020, 12000);
      md(2'b11);
      repeat (30) @(posedge clk_sys);
      wst("reserved keeps", 32'h0000_0007, 32'(dml_pkg::ST_NORMAL), 1);
      md(2'b00);
   endtask
   task t_auto();
      logic [31:0] d;
      @(posedge clk_sys);
      per1 <= 12'd1400;
      ref_en <= 2'b10;
      wst("auto hold", 32'h0000_0037, 32'h0000_0012, 2000);
      @(posedge clk_sys);
      ref_source_select <= 1'b1;
      repeat (3000) @(posedge clk_sys);
      rd(dml_pkg::REG_STATUS, d);
      chk("shifted ref", d & 32'h0000_0037, 32'h0000_0012);
      @(posedge clk_sys);
      per1 <= 12'd1250;
      wst("recover", 32'h0000_0017, 32'(dml_pkg::ST_NORMAL), 2500);
   endtask
   task t_ctrl();
      logic any = 1'b0;
      int tl = 0, t2 = 0, t8 = 0, t16 = 0;
      md(2'b10);
      wst("free", 32'h0000_0017, 32'(dml_pkg::ST_FREE), 10);
      wr(dml_pkg::REG_CTRL, 32'h0000_0000);
      repeat (100) begin
         @(posedge clk_sys);
         #1 any = any | clk_2m_out | clk_8m_out | clk_16m_out | !frame_pulse_out_n;
         tl += int'(synth_link_out != ja_19m_out);
      end
      chk("gated outputs", 32'(any), 32'h0000_0000);
      chk("link runs", 32'(tl != 0), 32'h0000_0001);
      wr(dml_pkg::REG_CTRL, 32'h0000_0001);
      repeat (100) begin
         @(posedge clk_sys);
         #1 t2 += int'(clk_2m_out);
         t8 += int'(clk_8m_out);
         t16 += int'(clk_16m_out);
      end
      chk("clk 2m", 32'(t2 > 0 && t2 < 100), 32'h0000_0001);
      chk("clk 8m", 32'(t8 > 0 && t8 < 100), 32'h0000_0001);
      chk("clk 16m", 32'(t16 > 0 && t16 < 100), 32'h0000_0001);
   endtask
   // ----------------------------------------------------------------
   // Clock, reset and sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (90000) @(posedge clk_sys);
      fails++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      {mode_select_high, mode_select_low} = 2'b10;
      ref_source_select = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      ref_en = 2'b00;
      per0 = 12'd1250;
      per1 = 12'd1250;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_init();
      t_hold();
      t_normal();
      t_auto();
      t_ctrl();
      end_of_test();
   end
endmodule
